/* File: dv/vagc_monitor.sv */
// property checker bound to the gain control top
`timescale 1ns/1ps
module vagc_monitor #(
   parameter int GAIN_W = 8,
   parameter int HOLD_W = 16
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // watched inputs
   input wire logic agc_enable_i,
   input wire logic [GAIN_W-1:0] gain_max_i,
   input wire logic [GAIN_W-1:0] gain_min_i,
   input wire logic [HOLD_W-1:0] hold_time_i,
   input wire logic in_valid_i,
   // watched outputs
   input wire logic out_valid_o,
   input wire logic [GAIN_W-1:0] gain_o,
   input wire logic voice_active_o,
   input wire logic [2:0] region_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   // ************************************************************
   // assertions
   // ************************************************************
   a_out_pulse: assert property (out_valid_o == $past(in_valid_i))
      else $error("output pulse not one cycle after input");
   a_disable_unity: assert property (!agc_enable_i |=>
      gain_o == vagc_pkg::GAIN_RST && region_o == 3'd0 && !voice_active_o)
      else $error("disabled block not at unity gain");
   a_gain_in_range: assert property (
      agc_enable_i && $past(agc_enable_i) && gain_min_i <= gain_max_i |->
      gain_o >= gain_min_i && gain_o <= gain_max_i)
      else $error("gain outside limits");
   a_gain_step_one: assert property (
      agc_enable_i && $past(agc_enable_i) && region_o != 3'd4 &&
      $past(region_o) != 3'd4 |-> 8'(gain_o - $past(gain_o) + 8'h01) <= 8'h02)
      else $error("gain step larger than one");
   a_inc_no_fall: assert property (
      agc_enable_i && $past(agc_enable_i) && $past(region_o) == 3'd1 &&
      region_o == 3'd1 |-> gain_o >= $past(gain_o))
      else $error("gain fell while increasing");
   a_dec_no_rise: assert property (
      agc_enable_i && $past(agc_enable_i) && $past(region_o) inside
      {3'd3, 3'd4} && region_o == $past(region_o) |-> gain_o <= $past(gain_o))
      else $error("gain rose while decreasing");
   a_idle_dec1: assert property (
      !$past(voice_active_o) && !voice_active_o |-> region_o == 3'd0)
      else $error("inactive block not in first decreasing region");
   a_active_region: assert property (
      $past(voice_active_o) && voice_active_o |-> region_o != 3'd0)
      else $error("active block in noise region");
   a_hold_freeze: assert property (
      agc_enable_i && region_o == 3'd2 && $past(region_o) inside
      {3'd0, 3'd3, 3'd4} && hold_time_i > 16'h0010 |=> $stable(gain_o) [*4])
      else $error("gain moved during hold");
   // main scenarios reached
   c_fast: cover property (region_o == 3'd4);
   c_hold: cover property (region_o == 3'd2 && $past(region_o) == 3'd3);
   c_active: cover property ($rose(voice_active_o));
endmodule : vagc_monitor

bind vagc_top vagc_monitor #(.GAIN_W(GAIN_W), .HOLD_W(HOLD_W)) i_vagc_monitor (
   .core_clk_i(core_clk_i), .srst_i(srst_i), .agc_enable_i(agc_enable_i),
   .gain_max_i(gain_max_i), .gain_min_i(gain_min_i),
   .hold_time_i(hold_time_i), .in_valid_i(in_valid_i),
   .out_valid_o(out_valid_o), .gain_o(gain_o),
   .voice_active_o(voice_active_o), .region_o(region_o));

/* File: dv/vagc_tb_top.sv */
// self-checking bench of the voice gain control
`timescale 1ns/1ps
module vagc_tb_top;
   // ************************************************************
   // signals
   // ************************************************************
   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic en = 1'b0;
   logic run = 1'b0;
   logic [14:0] mag = 15'h0000;
   logic [14:0] base = 15'h0000;
   logic [15:0] hold = 16'h0000;
   logic [3:0] slow_tc = 4'hf;
   logic [3:0] rise_tc = 4'h0, atk_tc = 4'h0, fall_tc = 4'h0, pw_tc = 4'h1;
   logic [7:0] gmax = 8'h40, gmin = 8'h04, ginit = 8'h0c, g0;
   logic [31:0] lfsr = 32'h0000fd52;
   int fail_count = 0;
   int n_checks = 0;
   logic vld, ovld, act;
   logic signed [15:0] smp, osmp, prev;
   logic [7:0] gain;
   logic [2:0] rgn;

   always #20 core_clk_i = ~core_clk_i;

   // ************************************************************
   // design and far side
   // ************************************************************
   vagc_voice_src i_vagc_voice_src (.core_clk_i(core_clk_i), .srst_i(srst_i),
      .run_i(run), .mag_i(mag), .valid_o(vld), .sample_o(smp));
   vagc_top i_vagc_top (.core_clk_i(core_clk_i), .srst_i(srst_i),
      .agc_enable_i(en), .target_level_high_i(16'h0bb8),
      .target_level_low_i(16'h07d0), .target_level_clip_i(16'h1388),
      .noise_threshold_upper_i(16'h0190), .noise_threshold_lower_i(16'h00c8),
      .rise_time_constant_i(rise_tc), .slow_rise_time_constant_i(slow_tc),
      .attack_time_constant_i(atk_tc), .noise_fall_time_constant_i(fall_tc),
      .power_time_constant_i(pw_tc), .gain_max_i(gmax), .gain_min_i(gmin),
      .gain_initial_i(ginit), .hold_time_i(hold), .in_valid_i(vld),
      .in_sample_i(smp), .out_valid_o(ovld), .out_sample_o(osmp),
      .gain_o(gain), .voice_active_o(act), .region_o(rgn));

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   // n samples around base with random jitter, or fully random when pass; pass compares unity output
   task automatic run_for(input int n, input logic pass);
      repeat (n) begin
         @(posedge core_clk_i);
         lfsr = nxt(lfsr);
         mag <= pass ? lfsr[14:0] : base + {9'h000, lfsr[5:0]};
         #1;
         if (pass && ovld === 1'b1) check(osmp, prev);
         prev = smp;
      end
   endtask : run_for

   // bounded wait for a region, run ends on timeout
   task automatic wait_rgn(input logic [2:0] r, input int lim);
      for (int i = 0; i < lim && rgn !== r; i++) run_for(1, 1'b0);
      check(rgn, r);
      if (rgn !== r) end_sim();
   endtask : wait_rgn

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      lfsr = nxt(lfsr);
      rise_tc = {3'h0, lfsr[0]};
      atk_tc = {3'h0, lfsr[1]};
      fall_tc = {3'h0, lfsr[2]};
      pw_tc = {3'h0, lfsr[3]} + 4'h1;
      gmax = 8'h40 | {4'h0, lfsr[7:4]};
      ginit = 8'h0c + {6'h00, lfsr[9:8]};
      repeat (20) @(posedge core_clk_i);
      srst_i <= 1'b0;
      #1;
      check({gain, rgn, act, ovld}, {8'h10, 3'd0, 2'b00});
      run <= 1'b1;
      run_for(200, 1'b1);
      $display("test passthrough done");
      // settle both power estimates at speech level before enabling
      base = 15'd1000;
      run_for(50, 1'b0);
      en <= 1'b1;
      wait_rgn(3'd1, 300);
      check(act, 1'b1);
      wait_rgn(3'd2, 3000);
      check(gain > 8'h10, 1'b1);
      $display("test activate done");
      base = 15'd20;
      wait_rgn(3'd0, 3000);
      for (int i = 0; i < 3000 && gain !== ginit; i++) run_for(1, 1'b0);
      check({gain, act}, {ginit, 1'b0});
      if (gain !== ginit) end_sim();
      $display("test noise done");
      base = 15'd8000;
      wait_rgn(3'd4, 1000);
      hold <= 16'd300;
      slow_tc <= 4'h0;
      wait_rgn(3'd3, 2000);
      wait_rgn(3'd2, 3000);
      run_for(2, 1'b0);
      g0 = gain;
      run_for(100, 1'b0);
      check(gain, g0);
      // hold runs out, then the window region creeps the gain up
      for (int i = 0; i < 400 && gain === g0; i++) run_for(1, 1'b0);
      check(gain, g0 + 8'h01);
      wait_rgn(3'd3, 400);
      $display("test loud and hold done");
      en <= 1'b0;
      run_for(2, 1'b0);
      check({gain, rgn}, {8'h10, 3'd0});
      $display("test disable done");
      end_sim();
   end
endmodule : vagc_tb_top

/* File: dv/vagc_voice_src.sv */
// voice sample path model: alternating sign source feeding the block
`timescale 1ns/1ps
module vagc_voice_src (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // control from the bench
   input wire logic run_i,
   input wire logic [14:0] mag_i,
   // sample stream toward the block
   output logic valid_o,
   output logic signed [vagc_pkg::SAMPLE_W-1:0] sample_o
);
   logic sign_ff;
   // one sample a cycle; idle line toggles so stale data never looks valid
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         valid_o <= 1'b0;
         sample_o <= 16'h0000;
         sign_ff <= 1'b0;
      end else if (run_i) begin
         valid_o <= 1'b1;
         sign_ff <= ~sign_ff;
         sample_o <= sign_ff ? -$signed({1'b0, mag_i}) : {1'b0, mag_i};
      end else begin
         valid_o <= 1'b0;
         sample_o <= ~sample_o;
      end
   end
endmodule : vagc_voice_src

/* File: src/vagc_pkg.sv */
// package of constants and types for the voice gain control
package vagc_pkg;
   // ************************************************************
   // widths
   // ************************************************************
   localparam int SAMPLE_W = 16;
   localparam int GAIN_W = 8;
   localparam int POWER_W = 16;
   localparam int TC_W = 4;
   localparam int HOLD_W = 16;
   localparam int ACC_W = 20;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [GAIN_W-1:0] GAIN_RST = 8'h10;   // unity gain, q4.4
   localparam logic [POWER_W-1:0] POWER_RST = 16'h0000;
   localparam int GAIN_FRAC = 4;                     // fraction bits of gain
   localparam int FAST_SHIFT = 2;                    // fast cut step scale

   // ************************************************************
   // regions
   // ************************************************************
   typedef enum logic [2:0] {
      VAGC_DEC1,
      VAGC_INC1,
      VAGC_TARGET,
      VAGC_DEC2,
      VAGC_FAST
   } vagc_region_t;
endpackage : vagc_pkg

/* File: src/vagc_power_est.sv */
// short-term power estimator: leaky average of sample magnitude
`timescale 1ns/1ps
module vagc_power_est #(
   parameter int SAMPLE_W = 16,
   parameter int POWER_W = 16,
   parameter int TC_W = 4
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // sample stream
   input wire logic sample_valid_i,
   input wire logic signed [SAMPLE_W-1:0] sample_i,
   input wire logic [TC_W-1:0] shift_i,
   // estimate
   output logic [POWER_W-1:0] power_o
);
   logic [POWER_W+15:0] acc_ff;
   logic [POWER_W+15:0] nxt_acc;
   logic [SAMPLE_W-1:0] mag;

   // magnitude, then acc += (mag<<16 - acc) >> shift
   always_comb begin
      mag = sample_i[SAMPLE_W-1] ? SAMPLE_W'(-sample_i) : sample_i;
      nxt_acc = acc_ff;
      if (sample_valid_i) begin
         nxt_acc = acc_ff - (acc_ff >> shift_i)
            + ({mag, 16'h0000} >> shift_i);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         acc_ff <= '0;
      end else begin
         acc_ff <= nxt_acc;
      end
   end

   assign power_o = acc_ff[POWER_W+15:16];
endmodule : vagc_power_est

/* File: src/vagc_step_timer.sv */
// time constant divider: pulses every 2**tc sample ticks
`timescale 1ns/1ps
module vagc_step_timer #(
   parameter int TC_W = 4,
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // control
   input wire logic tick_i,
   input wire logic restart_i,
   input wire logic [TC_W-1:0] tc_i,
   // step pulse
   output logic step_o
);
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic [CNT_W-1:0] limit;

   // count ticks up to the limit of the current time constant
   always_comb begin
      limit = CNT_W'((32'd1 << tc_i) - 32'd1);
      step_o = tick_i && (cnt_ff >= limit);
      nxt_cnt = cnt_ff;
      if (restart_i || step_o) begin
         nxt_cnt = '0;
      end else if (tick_i) begin
         nxt_cnt = cnt_ff + CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule : vagc_step_timer

/* File: src/vagc_top.sv */
// voice automatic gain control top: regions, gain stepping, hold
`timescale 1ns/1ps

// Functional notes
// - steer output level into high/low target window
// - activate above upper, release below lower noise
// - increasing region raises gain at rise constant
// - target region raises slowly, capped at maximum
// - above high target enter second decreasing region
// - second decreasing region lowers at attack constant
// - above clip target cut gain fast
// - noise: decay gain to initial at fall constant
// - restart hold timer on decreasing to target
// - freeze gain until nonzero hold time reached
module vagc_top #(
   parameter int SAMPLE_W = vagc_pkg::SAMPLE_W,
   parameter int GAIN_W = vagc_pkg::GAIN_W,
   parameter int POWER_W = vagc_pkg::POWER_W,
   parameter int TC_W = vagc_pkg::TC_W,
   parameter int HOLD_W = vagc_pkg::HOLD_W
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // configuration
   input wire logic agc_enable_i,
   input wire logic [POWER_W-1:0] target_level_high_i,
   input wire logic [POWER_W-1:0] target_level_low_i,
   input wire logic [POWER_W-1:0] target_level_clip_i,
   input wire logic [POWER_W-1:0] noise_threshold_upper_i,
   input wire logic [POWER_W-1:0] noise_threshold_lower_i,
   input wire logic [TC_W-1:0] rise_time_constant_i,
   input wire logic [TC_W-1:0] slow_rise_time_constant_i,
   input wire logic [TC_W-1:0] attack_time_constant_i,
   input wire logic [TC_W-1:0] noise_fall_time_constant_i,
   input wire logic [TC_W-1:0] power_time_constant_i,
   input wire logic [GAIN_W-1:0] gain_max_i,
   input wire logic [GAIN_W-1:0] gain_min_i,
   input wire logic [GAIN_W-1:0] gain_initial_i,
   input wire logic [HOLD_W-1:0] hold_time_i,
   // input samples
   input wire logic in_valid_i,
   input wire logic signed [SAMPLE_W-1:0] in_sample_i,
   // output samples
   output logic out_valid_o,
   output logic signed [SAMPLE_W-1:0] out_sample_o,
   // status
   output logic [GAIN_W-1:0] gain_o,
   output logic voice_active_o,
   output logic [2:0] region_o
);
   // ************************************************************
   // declarations
   // ************************************************************
   localparam int PROD_W = SAMPLE_W + GAIN_W + 1;
   // signed limits keep the saturation compares signed
   localparam logic signed [PROD_W-1:0] SAT_HI =
      PROD_W'((1 << (SAMPLE_W - 1)) - 1);
   localparam logic signed [PROD_W-1:0] SAT_LO = -SAT_HI;
   logic [POWER_W-1:0] in_power;
   logic [POWER_W-1:0] out_power;
   logic active_ff;
   logic nxt_active;
   vagc_pkg::vagc_region_t region_ff;
   vagc_pkg::vagc_region_t nxt_region;
   logic [GAIN_W-1:0] gain_ff;
   logic [GAIN_W-1:0] nxt_gain;
   logic [HOLD_W-1:0] hold_ff;
   logic [HOLD_W-1:0] nxt_hold;
   logic out_valid_ff;
   logic nxt_out_valid;
   logic signed [SAMPLE_W-1:0] out_sample_ff;
   logic signed [SAMPLE_W-1:0] nxt_out_sample;
   logic [TC_W-1:0] step_tc;
   logic step;
   logic region_change;
   logic holding;
   logic [GAIN_W:0] gain_up;
   logic [GAIN_W:0] gain_dn;
   logic [GAIN_W:0] fast_dn;
   logic [GAIN_W-1:0] raw_gain;
   logic signed [PROD_W-1:0] prod;
   logic signed [PROD_W-1:0] scaled;
   logic [GAIN_W-1:0] lo_lim;
   logic [GAIN_W-1:0] hi_lim;

   // ************************************************************
   // power estimation
   // ************************************************************
   // input power drives voice activity detection
   vagc_power_est #(
      .SAMPLE_W(SAMPLE_W),
      .POWER_W(POWER_W),
      .TC_W(TC_W)
   ) u_in_power (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .sample_valid_i(in_valid_i),
      .sample_i(in_sample_i),
      .shift_i(power_time_constant_i),
      .power_o(in_power)
   );

   // output power places the voice against the target window
   vagc_power_est #(
      .SAMPLE_W(SAMPLE_W),
      .POWER_W(POWER_W),
      .TC_W(TC_W)
   ) u_out_power (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .sample_valid_i(out_valid_ff),
      .sample_i(out_sample_ff),
      .shift_i(power_time_constant_i),
      .power_o(out_power)
   );

   // ************************************************************
   // gain step timing
   // ************************************************************
   // time constant selected by the current region
   always_comb begin
      case (region_ff)
         vagc_pkg::VAGC_INC1: step_tc = rise_time_constant_i;
         vagc_pkg::VAGC_TARGET: step_tc = slow_rise_time_constant_i;
         vagc_pkg::VAGC_DEC2: step_tc = attack_time_constant_i;
         vagc_pkg::VAGC_FAST: step_tc = '0;
         default: step_tc = noise_fall_time_constant_i;
      endcase
   end

   assign region_change = (nxt_region != region_ff);

   vagc_step_timer #(
      .TC_W(TC_W),
      .CNT_W(16)
   ) u_step (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .tick_i(in_valid_i),
      .restart_i(region_change),
      .tc_i(step_tc),
      .step_o(step)
   );

   // ************************************************************
   // voice activity and region selection
   // ************************************************************
   always_comb begin
      nxt_active = active_ff;
      if (!agc_enable_i) begin
         nxt_active = 1'b0;
      end else if (in_power > noise_threshold_upper_i) begin
         nxt_active = 1'b1;
      end else if (in_power < noise_threshold_lower_i) begin
         nxt_active = 1'b0;
      end
      nxt_region = region_ff;
      if (!nxt_active) begin
         nxt_region = vagc_pkg::VAGC_DEC1;
      end else begin
         case (region_ff)
            vagc_pkg::VAGC_DEC1: begin
               nxt_region = vagc_pkg::VAGC_INC1;
            end
            vagc_pkg::VAGC_INC1: begin
               if (out_power >= target_level_low_i ||
                   gain_ff >= gain_max_i) begin
                  nxt_region = vagc_pkg::VAGC_TARGET;
               end
            end
            vagc_pkg::VAGC_TARGET: begin
               if (out_power > target_level_clip_i) begin
                  nxt_region = vagc_pkg::VAGC_FAST;
               end else if (out_power > target_level_high_i) begin
                  nxt_region = vagc_pkg::VAGC_DEC2;
               end
            end
            vagc_pkg::VAGC_DEC2: begin
               if (out_power > target_level_clip_i) begin
                  nxt_region = vagc_pkg::VAGC_FAST;
               end else if (out_power <= target_level_high_i) begin
                  nxt_region = vagc_pkg::VAGC_TARGET;
               end
            end
            vagc_pkg::VAGC_FAST: begin
               if (out_power <= target_level_clip_i) begin
                  nxt_region = vagc_pkg::VAGC_DEC2;
               end
            end
            default: nxt_region = vagc_pkg::VAGC_DEC1;
         endcase
      end
   end

   // ************************************************************
   // hold timer
   // ************************************************************
   always_comb begin
      nxt_hold = hold_ff;
      if (nxt_region == vagc_pkg::VAGC_TARGET &&
          (region_ff == vagc_pkg::VAGC_DEC2 ||
           region_ff == vagc_pkg::VAGC_FAST ||
           region_ff == vagc_pkg::VAGC_DEC1)) begin
         nxt_hold = '0;
      end else if (in_valid_i && hold_ff < hold_time_i) begin
         nxt_hold = hold_ff + HOLD_W'(1);
      end
   end

   assign holding = (hold_time_i != '0) && (hold_ff < hold_time_i);

   // ************************************************************
   // gain update
   // ************************************************************
   always_comb begin
      lo_lim = gain_min_i;
      hi_lim = (gain_max_i < gain_min_i) ? gain_min_i : gain_max_i;
      gain_up = {1'b0, gain_ff} + {{GAIN_W{1'b0}}, 1'b1};
      gain_dn = {1'b0, gain_ff} - {{GAIN_W{1'b0}}, 1'b1};
      fast_dn = {1'b0, gain_ff} - (GAIN_W + 1)'(1 << vagc_pkg::FAST_SHIFT);
      raw_gain = gain_ff;
      if (step && !holding) begin
         case (region_ff)
            vagc_pkg::VAGC_INC1: raw_gain = gain_up[GAIN_W] ?
               gain_ff : gain_up[GAIN_W-1:0];
            vagc_pkg::VAGC_TARGET: raw_gain = gain_up[GAIN_W] ?
               gain_ff : gain_up[GAIN_W-1:0];
            vagc_pkg::VAGC_DEC2: raw_gain = gain_dn[GAIN_W] ?
               '0 : gain_dn[GAIN_W-1:0];
            vagc_pkg::VAGC_FAST: raw_gain = fast_dn[GAIN_W] ?
               '0 : fast_dn[GAIN_W-1:0];
            default: begin
               if (gain_ff > gain_initial_i) begin
                  raw_gain = gain_dn[GAIN_W-1:0];
               end
            end
         endcase
      end
      if (raw_gain > hi_lim) begin
         nxt_gain = hi_lim;
      end else if (raw_gain < lo_lim) begin
         nxt_gain = lo_lim;
      end else begin
         nxt_gain = raw_gain;
      end
      if (!agc_enable_i) begin
         nxt_gain = vagc_pkg::GAIN_RST;
      end
   end

   // ************************************************************
   // sample scaling
   // ************************************************************
   // apply gain, saturate output
   always_comb begin
      prod = PROD_W'(in_sample_i) * $signed({1'b0, gain_ff});
      scaled = prod >>> vagc_pkg::GAIN_FRAC;
      nxt_out_valid = in_valid_i;
      nxt_out_sample = out_sample_ff;
      if (in_valid_i) begin
         if (scaled > SAT_HI) begin
            nxt_out_sample = {1'b0, {(SAMPLE_W-1){1'b1}}};
         end else if (scaled < SAT_LO) begin
            nxt_out_sample = {1'b1, {(SAMPLE_W-2){1'b0}}, 1'b1};
         end else begin
            nxt_out_sample = scaled[SAMPLE_W-1:0];
         end
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         active_ff <= 1'b0;
         region_ff <= vagc_pkg::VAGC_DEC1;
         gain_ff <= vagc_pkg::GAIN_RST;
         hold_ff <= '0;
         out_valid_ff <= 1'b0;
         out_sample_ff <= '0;
      end else begin
         active_ff <= nxt_active;
         region_ff <= nxt_region;
         gain_ff <= nxt_gain;
         hold_ff <= nxt_hold;
         out_valid_ff <= nxt_out_valid;
         out_sample_ff <= nxt_out_sample;
      end
   end

   // outputs straight from flip-flops
   assign out_valid_o = out_valid_ff;
   assign out_sample_o = out_sample_ff;
   assign gain_o = gain_ff;
   assign voice_active_o = active_ff;
   assign region_o = region_ff;
endmodule : vagc_top
